// *** vct_pkg.sv ***
package vct_pkg;
  localparam logic [3:0] SEL_RESERVED = 4'h8;
  localparam logic [3:0] SEL_CAL_TIMING = 4'h9;
  localparam logic [31:0] RESERVED_WORD = 32'h15596568;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;
  localparam int BAND_DIV_LSB = 24;
  localparam int BAND_DIV_MSB = 31;
  localparam int BST_LSB = 14;
  localparam int BST_MSB = 23;
  localparam int LCW_LSB = 9;
  localparam int LCW_MSB = 13;
  localparam int LSW_LSB = 4;
  localparam int LSW_MSB = 8;

  typedef struct packed {
    logic [7:0] band_div_field;
    logic [9:0] band_select_timeout;
    logic [4:0] level_cal_wait;
    logic [4:0] lock_settle_wait;
  } vct_timing_s;

  localparam vct_timing_s TIMING_RESET = '{8'h01, 10'h001, 5'h01, 5'h01};

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_BAND = 4'b0010,
    ST_LEVEL = 4'b0100,
    ST_SETTLE = 4'b1000
  } vct_state_e;
endpackage : vct_pkg

// *** vct_divider.sv ***
`timescale 1ns/10ps
module vct_divider #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [WIDTH-1:0] div,
  // tick out, one cycle every div cycles
  output logic tick
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  // zero divider treated as one so the tick never stops
  always_comb begin
    nxt_cnt = '0;
    nxt_tick = 1'b0;
    if (run) begin
      if (cnt_ff + WIDTH'(1) >= div) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule : vct_divider

// *** vct_timing_regs.sv ***
`timescale 1ns/10ps
module vct_timing_regs (
  // clock (phase compare rate) and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // latched serial word from the shift stage
  input wire logic word_load,
  input wire logic [31:0] word_data,
  // calibration request from elsewhere
  input wire logic cal_start,
  // timer settings and calibration progress
  output vct_pkg::vct_timing_s timing,
  output logic band_sel_clk_tick,
  output logic band_select_active,
  output logic level_cal_active,
  output logic lock_settle_active,
  output logic cal_done,
  output logic reserved_ok
);
  // counter width covers a full-scale timeout times a full-scale wait
  localparam int CNT_W = 15;
  // divider width matches the band division field
  localparam int DIV_W = 8;

  // register file
  vct_pkg::vct_timing_s timing_ff;
  vct_pkg::vct_timing_s nxt_timing;
  logic reserved_ok_ff;
  logic nxt_reserved_ok;
  // word decode
  logic load_timing;
  logic load_reserved;
  // calibration sequencer; a cal_start while busy is dropped without notice
  vct_pkg::vct_state_e state_ff;
  vct_pkg::vct_state_e nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] lim;
  logic phase_end;
  logic done_ff;
  logic nxt_done;
  // progress flags, registered so the pins never glitch
  logic band_act_ff;
  logic nxt_band_act;
  logic level_act_ff;
  logic nxt_level_act;
  logic settle_act_ff;
  logic nxt_settle_act;
  // band-select clock
  logic div_run;
  logic div_tick;
  logic tick_ff;
  logic nxt_tick;

  // select code sits in the low bits of every serial word
  function automatic logic sel_match(input logic [31:0] w, input logic [3:0] code);
    sel_match = (w[vct_pkg::SEL_MSB:vct_pkg::SEL_LSB] == code);
  endfunction : sel_match

  // widened before the product so nothing wraps
  function automatic logic [CNT_W-1:0] scaled(input logic [9:0] t, input logic [4:0] w);
    scaled = CNT_W'(t) * CNT_W'(w);
  endfunction : scaled

  // divider runs only while calibrating, so each run starts from zero
  always_comb begin
    div_run = (state_ff != vct_pkg::ST_IDLE);
  end

  vct_divider #(.WIDTH(DIV_W)) u_div (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(div_run),
    .div(timing_ff.band_div_field),
    .tick(div_tick)
  );

  // word decode
  always_comb begin
    load_timing = word_load && sel_match(word_data, vct_pkg::SEL_CAL_TIMING);
    load_reserved = word_load && sel_match(word_data, vct_pkg::SEL_RESERVED);
  end

  // timing register; a rewrite mid-calibration takes effect at once
  always_comb begin
    nxt_timing = timing_ff;
    if (load_timing) begin
      nxt_timing.band_div_field = word_data[vct_pkg::BAND_DIV_MSB:vct_pkg::BAND_DIV_LSB];
      nxt_timing.band_select_timeout = word_data[vct_pkg::BST_MSB:vct_pkg::BST_LSB];
      nxt_timing.level_cal_wait = word_data[vct_pkg::LCW_MSB:vct_pkg::LCW_LSB];
      nxt_timing.lock_settle_wait = word_data[vct_pkg::LSW_MSB:vct_pkg::LSW_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timing_ff <= vct_pkg::TIMING_RESET;
    end else begin
      timing_ff <= nxt_timing;
    end
  end

  // reserved word is only checked, it steers nothing here
  always_comb begin
    nxt_reserved_ok = reserved_ok_ff;
    if (load_reserved) begin
      nxt_reserved_ok = (word_data == vct_pkg::RESERVED_WORD);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reserved_ok_ff <= 1'b0;
    end else begin
      reserved_ok_ff <= nxt_reserved_ok;
    end
  end

  // band-select clock pin, one cycle behind the divider
  always_comb begin
    nxt_tick = div_tick;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  // limit of the running phase in band-select clock periods
  always_comb begin
    case (state_ff)
      vct_pkg::ST_BAND: lim = CNT_W'(timing_ff.band_select_timeout);
      vct_pkg::ST_LEVEL: begin
        lim = scaled(timing_ff.band_select_timeout, timing_ff.level_cal_wait);
      end
      vct_pkg::ST_SETTLE: begin
        lim = scaled(timing_ff.band_select_timeout, timing_ff.lock_settle_wait);
      end
      default: lim = '0;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    case (state_ff)
      vct_pkg::ST_IDLE: begin
        nxt_cnt = '0;
        if (cal_start) begin
          nxt_state = vct_pkg::ST_BAND;
        end
      end
      vct_pkg::ST_BAND, vct_pkg::ST_LEVEL, vct_pkg::ST_SETTLE: begin
        if (div_tick) begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
        // zero count ends the phase at once
        if (phase_end) begin
          nxt_cnt = '0;
          case (state_ff)
            vct_pkg::ST_BAND: nxt_state = vct_pkg::ST_LEVEL;
            vct_pkg::ST_LEVEL: nxt_state = vct_pkg::ST_SETTLE;
            default: begin
              nxt_state = vct_pkg::ST_IDLE;
              nxt_done = 1'b1;
            end
          endcase
        end
      end
      default: nxt_state = vct_pkg::ST_IDLE;
    endcase
  end

  // phase end decode
  always_comb begin
    phase_end = (cnt_ff >= lim);
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= vct_pkg::ST_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  // flags follow the next state so they line up with state_ff
  always_comb begin
    nxt_band_act = (nxt_state == vct_pkg::ST_BAND);
    nxt_level_act = (nxt_state == vct_pkg::ST_LEVEL);
    nxt_settle_act = (nxt_state == vct_pkg::ST_SETTLE);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      band_act_ff <= 1'b0;
      level_act_ff <= 1'b0;
      settle_act_ff <= 1'b0;
    end else begin
      band_act_ff <= nxt_band_act;
      level_act_ff <= nxt_level_act;
      settle_act_ff <= nxt_settle_act;
    end
  end

  // every output pin comes straight from a register
  assign timing = timing_ff;
  assign band_sel_clk_tick = tick_ff;
  assign band_select_active = band_act_ff;
  assign level_cal_active = level_act_ff;
  assign lock_settle_active = settle_act_ff;
  assign cal_done = done_ff;
  assign reserved_ok = reserved_ok_ff;
endmodule : vct_timing_regs

// *** vct_timing_regs_monitor.sv ***
`timescale 1ns/10ps
module vct_timing_regs_monitor (
  // clock, reset, word in
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic word_load,
  input wire logic [31:0] word_data,
  // settings and progress out
  input wire vct_pkg::vct_timing_s timing,
  input wire logic band_sel_clk_tick,
  input wire logic band_select_active,
  input wire logic level_cal_active,
  input wire logic lock_settle_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire ld9 = word_load && word_data[3:0] == 4'h9;
  wire busy = band_select_active | level_cal_active | lock_settle_active;
  chk_other_sel: assert property (word_load && !ld9 |=> $stable(timing))
    else $error("timing moved");
  chk_div_load: assert property (ld9 |=>
    timing.band_div_field == $past(word_data[31:24])) else $error("div");
  chk_tmo_load: assert property (ld9 |=>
    timing.band_select_timeout == $past(word_data[23:14])) else $error("timeout");
  chk_lvl_load: assert property (ld9 |=>
    timing.level_cal_wait == $past(word_data[13:9])) else $error("level wait");
  chk_stl_load: assert property (ld9 |=>
    timing.lock_settle_wait == $past(word_data[8:4])) else $error("settle wait");
  // spacing judged only at the divider the bench uses
  chk_tick_gap: assert property (band_sel_clk_tick && timing.band_div_field == 8'h0d |=>
    !band_sel_clk_tick [*8] ##1 !band_sel_clk_tick [*4] ##1 (band_sel_clk_tick || !busy))
    else $error("tick gap");
  chk_phase_seq: assert property ($fell(band_select_active) |-> level_cal_active)
    else $error("phase order");
  cover property (ld9);
  cover property ($rose(level_cal_active));
  cover property ($fell(lock_settle_active));
endmodule : vct_timing_regs_monitor
bind vct_timing_regs vct_timing_regs_monitor mon (.*);

// *** vct_host_model.sv ***
`timescale 1ns/10ps
module vct_host_model (
  // clock
  input wire logic ref_clk,
  // latched word
  output logic word_load = 1'b0,
  output logic [31:0] word_data = 32'h0
);
  localparam int RATE_MHZ = 20;
  localparam int TMO = 40;
  localparam int DIV = (RATE_MHZ * 10 + 15) / 16;
  localparam int LVL = 50 * RATE_MHZ / TMO + 1;
  localparam int STL = 20 * RATE_MHZ / TMO + 1;
  localparam logic [31:0] TW = {DIV[7:0], TMO[9:0], LVL[4:0], STL[4:0], 4'h9};
  task automatic put(input logic [31:0] w);
    @(posedge ref_clk);
    word_load <= 1'b1;
    word_data <= w;
    @(posedge ref_clk);
    word_load <= 1'b0;
    word_data <= ~w; // released word must not look valid
  endtask : put
endmodule : vct_host_model

// *** vct_timing_regs_bench.sv ***
`timescale 1ns/10ps
module vct_timing_regs_bench;
  logic ref_clk = 1'b0, rst_b = 1'b0, cal_start = 1'b0;
  logic word_load, band_sel_clk_tick, band_select_active, level_cal_active;
  logic lock_settle_active, cal_done, reserved_ok;
  logic [31:0] word_data;
  vct_pkg::vct_timing_s timing;
  int err_total = 0, checks_done = 0, cyc = 0, nb = 0, nl = 0, ns = 0;
  vct_host_model host (.*);
  vct_timing_regs dut (.*);
  wire [31:0] tw = host.TW;
  always #25 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic start;
    @(posedge ref_clk);
    cal_start <= 1'b1;
    @(posedge ref_clk);
    cal_start <= 1'b0;
  endtask : start
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    nb <= nb + int'(band_select_active & band_sel_clk_tick);
    nl <= nl + int'(level_cal_active & band_sel_clk_tick);
    ns <= ns + int'(lock_settle_active & band_sel_clk_tick);
    if (cyc == 40000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    host.put(32'h15596568);
    host.put(tw);
    host.put({~tw[31:4], 4'ha});
    @(negedge ref_clk);
    check(32'(reserved_ok), 32'h1);
    check(32'(timing), 32'(tw[31:4]));
    $display("load test done");
    start();
    @(negedge ref_clk);
    check(32'({band_select_active, level_cal_active, lock_settle_active}), 32'h4);
    repeat (99) @(posedge ref_clk);
    start(); // busy, so no restart
    while (cal_done !== 1'b1) @(posedge ref_clk);
    @(negedge ref_clk);
    check(nb, 32'(tw[23:14]));
    check(nl, 32'(tw[23:14]) * tw[13:9]);
    check(ns, 32'(tw[23:14]) * tw[8:4]);
    check(32'({band_select_active, level_cal_active, lock_settle_active, cal_done}), 32'h0);
    $display("calibration test done");
    complete_run();
  end
endmodule : vct_timing_regs_bench
